// ---- dtc_pkg.sv ----
// Purpose: constants for the termination control block
// Assumes: 40 MHz system clock, one DRAM clock per write_cmd sample
// Notes: register byte offsets are word aligned on APB
package dtc_pkg;
    // Register offsets
    localparam logic [7:0] DTC_CTRL_OFF = 8'h00;
    localparam logic [7:0] DTC_LAT_OFF = 8'h04;
    localparam logic [7:0] DTC_STAT_OFF = 8'h08;
    // Control field positions
    localparam int DTC_DLL_EN_BIT = 0;
    localparam int DTC_WR9_BIT = 1;
    localparam int DTC_WR10_BIT = 2;
    localparam int DTC_PRE2_BIT = 3;
    localparam int DTC_CRC_BIT = 4;
    localparam int DTC_BUFDIS_BIT = 5;
    localparam logic [31:0] DTC_CTRL_RST = 32'h0000_0001;
    // Latency field positions (6 bits each)
    localparam int DTC_CWL_LSB = 0;
    localparam int DTC_AL_LSB = 8;
    localparam int DTC_PL_LSB = 16;
    localparam logic [31:0] DTC_LAT_RST = 32'h0000_0009;
    // Write-off extra latencies beyond write_term_on_latency
    localparam logic [3:0] DTC_OFF_BC4_1T = 4'h4;
    localparam logic [3:0] DTC_OFF_BL8_1T = 4'h6;
    localparam logic [3:0] DTC_OFF_CRC_1T = 4'h7;
    localparam logic [3:0] DTC_OFF_BC4_2T = 4'h5;
    localparam logic [3:0] DTC_OFF_BL8_2T = 4'h7;
    localparam logic [3:0] DTC_OFF_CRC_2T = 4'h8;
    // Asynchronous mode timing
    localparam int DTC_CLK_PS = 25000;
    localparam int DTC_ASYNC_MIN_PS = 1000;
    localparam int DTC_ASYNC_MAX_PS = 9000;
    localparam int DTC_ASYNC_MIN_CYC =
        (DTC_ASYNC_MIN_PS + DTC_CLK_PS - 1) / DTC_CLK_PS;
    localparam int DTC_ASYNC_MAX_CYC =
        (DTC_ASYNC_MAX_PS / DTC_CLK_PS) < 1 ? 1 : (DTC_ASYNC_MAX_PS / DTC_CLK_PS);
    // Termination encoding
    typedef enum logic [1:0] {
        DTC_RTT_PARK = 2'h0,
        DTC_RTT_NOM = 2'h1,
        DTC_RTT_WR = 2'h3
    } dtc_rtt_t;
    localparam int DTC_SR_LEN = 64;
endpackage

// ---- dtc_delay_line.sv ----
// Purpose: shift register tapped at a run-time latency
// Assumes: latency below DTC_SR_LEN
// Notes: tap 0 means the input delayed by one edge
`timescale 1ns/1ps
module dtc_delay_line
    import dtc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Data
    input wire logic din_i,
    input wire logic [5:0] tap_i,
    output logic dout_o
);
    logic [DTC_SR_LEN-1:0] sr_r;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            sr_r <= '0;
        end else begin
            sr_r <= {sr_r[DTC_SR_LEN-2:0], din_i};
        end
    end

    assign dout_o = sr_r[tap_i];
endmodule // dtc_delay_line

// ---- dtc_sync2.sv ----
// Purpose: two flip-flop synchroniser for a pin level
// Assumes: level inputs only
// Notes: first stage is read by the second only
`timescale 1ns/1ps
module dtc_sync2
    import dtc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Level
    input wire logic d_i,
    output logic q_o
);
    logic meta_r;
    logic q_r;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            meta_r <= 1'b0;
            q_r <= 1'b0;
        end else begin
            meta_r <= d_i;
            q_r <= meta_r;
        end
    end

    assign q_o = q_r;
endmodule // dtc_sync2

// ---- dtc_term_ctrl.sv ----
// Purpose: on-die termination select for a DRAM data bus
// Assumes: write_cmd_i, burst_bc4_i come from same-clock command decode
// Notes: odt and cke are pins and pass two flip-flops first
`timescale 1ns/1ps
module dtc_term_ctrl
    import dtc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // DRAM side
    input wire logic odt_pin_i,
    input wire logic cke_pin_i,
    input wire logic write_cmd_i,
    input wire logic burst_bc4_i,
    // Termination select
    output logic [1:0] rtt_sel_o,
    output logic rtt_changing_o
);
    logic [31:0] ctrl_r;
    logic [31:0] lat_r;
    logic odt_s;
    logic cke_s;
    logic cke_d_r;
    logic [5:0] wl_r;
    logic [5:0] on_lat_r;
    logic [3:0] off_extra;
    logic [5:0] off_cnt_r;
    logic wr_pend_r;
    logic wr_active_r;
    logic [5:0] on_cnt_r;
    logic nom_sync;
    logic pd_r;
    logic [5:0] pd_ign_r;
    logic [1:0] rtt_nxt;
    logic [1:0] rtt_r;
    logic [3:0] as_cnt_r;
    logic as_tgt_r;
    logic as_cur_r;
    logic dll_on;
    logic dyn_en;
    logic apb_acc;
    logic bufdis;

    dtc_sync2 u_sync_odt (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .d_i(odt_pin_i),
        .q_o(odt_s)
    );

    dtc_sync2 u_sync_cke (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .d_i(cke_pin_i),
        .q_o(cke_s)
    );

    assign apb_acc = psel_i & penable_i;
    assign dll_on = ctrl_r[DTC_DLL_EN_BIT];
    assign bufdis = ctrl_r[DTC_BUFDIS_BIT];
    assign dyn_en = (ctrl_r[DTC_WR9_BIT] | ctrl_r[DTC_WR10_BIT]) & dll_on;

    // Register writes
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ctrl_r <= DTC_CTRL_RST;
            lat_r <= DTC_LAT_RST;
        end else if (apb_acc && pwrite_i) begin
            if (paddr_i == DTC_CTRL_OFF) begin
                ctrl_r <= {26'h0, pwdata_i[5:0]};
            end
            if (paddr_i == DTC_LAT_OFF) begin
                lat_r <= {10'h0, pwdata_i[21:16], 2'h0, pwdata_i[13:8], 2'h0, pwdata_i[5:0]};
            end
        end
    end

    // Register reads, zero-wait answer
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            prdata_o <= 32'h0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= psel_i & ~pready_o & ~penable_i ? 1'b1 : 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0;
            if (psel_i && !penable_i) begin
                case (paddr_i)
                    DTC_CTRL_OFF: prdata_o <= ctrl_r;
                    DTC_LAT_OFF: prdata_o <= lat_r;
                    DTC_STAT_OFF: prdata_o <= {26'h0, pd_r, wr_active_r, as_cur_r,
                                               odt_s, rtt_r};
                    default: pslverr_o <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            wl_r <= 6'h9;
            on_lat_r <= 6'h7;
        end else begin
            wl_r <= 6'(lat_r[DTC_CWL_LSB +: 6] + lat_r[DTC_AL_LSB +: 6]
                       + lat_r[DTC_PL_LSB +: 6]);
            on_lat_r <= ctrl_r[DTC_PRE2_BIT] ? 6'(wl_r - 6'h3) : 6'(wl_r - 6'h2);
        end
    end

    always_comb begin
        case ({ctrl_r[DTC_PRE2_BIT], ctrl_r[DTC_CRC_BIT]})
            2'b00: off_extra = burst_bc4_i ? DTC_OFF_BC4_1T : DTC_OFF_BL8_1T;
            2'b01: off_extra = DTC_OFF_CRC_1T;
            2'b10: off_extra = burst_bc4_i ? DTC_OFF_BC4_2T : DTC_OFF_BL8_2T;
            default: off_extra = DTC_OFF_CRC_2T;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            wr_pend_r <= 1'b0;
            wr_active_r <= 1'b0;
            on_cnt_r <= 6'h0;
            off_cnt_r <= 6'h0;
        end else if (!dyn_en) begin
            wr_pend_r <= 1'b0;
            wr_active_r <= 1'b0;
        end else if (write_cmd_i) begin
            wr_pend_r <= 1'b1;
            on_cnt_r <= on_lat_r;
            off_cnt_r <= 6'(on_lat_r + {2'h0, off_extra});
        end else begin
            if (on_cnt_r != 6'h0) begin
                on_cnt_r <= on_cnt_r - 6'h1;
            end
            if (off_cnt_r != 6'h0) begin
                off_cnt_r <= off_cnt_r - 6'h1;
            end
            if (wr_pend_r && on_cnt_r == 6'h1) begin
                wr_active_r <= 1'b1;
            end
            if (off_cnt_r == 6'h1) begin
                wr_active_r <= 1'b0;
                wr_pend_r <= 1'b0;
            end
        end
    end

    dtc_delay_line u_odt_lat (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .din_i(odt_s),
        .tap_i(6'(on_lat_r - 6'h1)),
        .dout_o(nom_sync)
    );

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            cke_d_r <= 1'b1;
            pd_r <= 1'b0;
            pd_ign_r <= 6'h0;
        end else begin
            cke_d_r <= cke_s;
            pd_r <= bufdis & ~cke_s;
            if (bufdis && cke_d_r && !cke_s) begin
                pd_ign_r <= 6'(wl_r - 6'h1);
            end else if (pd_ign_r != 6'h0) begin
                pd_ign_r <= pd_ign_r - 6'h1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            as_tgt_r <= 1'b0;
            as_cur_r <= 1'b0;
            as_cnt_r <= 4'h0;
        end else if (odt_s != as_tgt_r) begin
            as_tgt_r <= odt_s;
            as_cnt_r <= 4'(DTC_ASYNC_MAX_CYC - 1);
            // Bound below one clock: apply at once, no extra counting stage
            if (DTC_ASYNC_MAX_CYC <= 1) begin
                as_cur_r <= odt_s;
            end
        end else if (as_cnt_r != 4'h0) begin
            as_cnt_r <= as_cnt_r - 4'h1;
            if (as_cnt_r == 4'h1) begin
                as_cur_r <= as_tgt_r;
            end
        end
    end

    always_comb begin
        rtt_nxt = DTC_RTT_PARK;
        if (!dll_on) begin
            rtt_nxt = (as_cur_r && !pd_r) ? DTC_RTT_NOM : DTC_RTT_PARK;
        end else if (wr_active_r) begin
            rtt_nxt = DTC_RTT_WR;
        end else if (nom_sync && !pd_r && pd_ign_r == 6'h0) begin
            rtt_nxt = DTC_RTT_NOM;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            rtt_r <= DTC_RTT_PARK;
            rtt_changing_o <= 1'b0;
        end else begin
            rtt_r <= rtt_nxt;
            rtt_changing_o <= (rtt_nxt != rtt_r);
        end
    end

    assign rtt_sel_o = rtt_r;

    // write termination arrives after on latency
    wr_on_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (dyn_en && write_cmd_i && on_lat_r == 6'h7 && !ctrl_r[DTC_PRE2_BIT]
         && !ctrl_r[DTC_CRC_BIT]) ##1 (dyn_en && !write_cmd_i)[*7]
        |-> ##2 rtt_sel_o == DTC_RTT_WR)
        else $error("write termination not applied on time");
    // no write termination with DLL off
    dll_off_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !$past(dll_on) && !dll_on |-> rtt_sel_o != DTC_RTT_WR)
        else $error("write termination with DLL off");
    pd_nom_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $past(pd_r) && pd_r |-> rtt_sel_o != DTC_RTT_NOM)
        else $error("nominal termination during power-down");
    async_on_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !dll_on && $rose(odt_s) ##1 (!dll_on && odt_s && !pd_r)[*2]
        |-> ##1 rtt_sel_o == DTC_RTT_NOM)
        else $error("async turn-on too slow");
    async_off_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !dll_on && $fell(odt_s) && rtt_sel_o == DTC_RTT_NOM |=> rtt_sel_o == DTC_RTT_NOM)
        else $error("async turn-off earlier than minimum");
    dyn_off_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !dyn_en ##1 !dyn_en |-> !wr_active_r)
        else $error("write window while switching disabled");
    bc4_len_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $rose(wr_active_r) && off_cnt_r == 6'h4 && !write_cmd_i ##1 (!write_cmd_i)[*3]
        |-> ##1 !wr_active_r)
        else $error("BC4 write window wrong length");
    wl_sum_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $stable(lat_r) |-> wl_r == 6'(lat_r[5:0] + lat_r[13:8] + lat_r[21:16]))
        else $error("write latency sum wrong");
    wr_on2_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (dyn_en && write_cmd_i && on_lat_r == 6'h6 && ctrl_r[DTC_PRE2_BIT])
        ##1 (dyn_en && !write_cmd_i)[*6] |-> ##2 rtt_sel_o == DTC_RTT_WR)
        else $error("long preamble write termination not applied on time");

    bl8_len_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $rose(wr_active_r) && off_cnt_r == 6'h6 && !write_cmd_i ##1 (!write_cmd_i)[*5]
        |-> ##1 !wr_active_r)
        else $error("BL8 write window wrong length");

    crc_len_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $rose(wr_active_r) && off_cnt_r == 6'h7 && !write_cmd_i ##1 (!write_cmd_i)[*6]
        |-> ##1 !wr_active_r)
        else $error("seven-clock write window wrong length");

    pd_ign_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $rose(pd_r) |-> pd_ign_r != 6'h0)
        else $error("power-down ignore window not armed");

    wr_prio_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        wr_active_r && dll_on |=> rtt_sel_o == DTC_RTT_WR)
        else $error("write termination lost priority");

    park_sel_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        dll_on && !wr_active_r && !nom_sync |=> rtt_sel_o == DTC_RTT_PARK)
        else $error("park termination not applied");

    // Change flag marks every select change
    rtt_chg_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        rtt_changing_o == (rtt_sel_o != $past(rtt_sel_o)))
        else $error("change flag disagrees with select");

    // Bus answer is a single-cycle pulse
    apb_one_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        pready_o |=> !pready_o)
        else $error("ready held longer than one cycle");

    // Error only with an answer
    apb_err_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        pslverr_o |-> pready_o)
        else $error("error flag without ready");

    wr_cov_c: cover property (@(posedge clk_sys_i) $rose(wr_active_r));
    pd_cov_c: cover property (@(posedge clk_sys_i) $rose(pd_r));
    nom_cov_c: cover property (@(posedge clk_sys_i) rtt_sel_o == DTC_RTT_NOM);
    as_cov_c: cover property (@(posedge clk_sys_i) !dll_on && $rose(as_cur_r));
endmodule // dtc_term_ctrl

// ---- dtc_ctl_model.sv ----
// Purpose: controller side model driving ODT, CKE and write commands
// Assumes: the bench calls its tasks; changes land just after a rising edge
// Notes: the burst flag shows the inverse of its last value between writes
`timescale 1ns/1ps
module dtc_ctl_model (
    // Clock
    input wire logic clk_sys_i,
    // Pins and command decode
    output logic odt_o,
    output logic cke_o,
    output logic wr_o,
    output logic bc4_o
);
    initial begin
        odt_o = 1'b0;
        cke_o = 1'b1;
        wr_o = 1'b0;
        bc4_o = 1'b0;
    end
    // One-cycle write command with its burst flag
    task automatic send_write(input logic bc4);
        @(posedge clk_sys_i);
        wr_o <= 1'b1;
        bc4_o <= bc4;
        @(posedge clk_sys_i);
        wr_o <= 1'b0;
        bc4_o <= ~bc4;
    endtask
    task automatic set_odt(input logic v);
        @(posedge clk_sys_i);
        odt_o <= v;
    endtask
    // pin low with CKE on exit
    task automatic power(input logic up);
        @(posedge clk_sys_i);
        cke_o <= up;
        if (up) begin
            odt_o <= 1'b0;
        end
    endtask
endmodule // dtc_ctl_model

// ---- test_dtc_term_ctrl.sv ----
// Purpose: self-checking bench for the termination control block
// Assumes: default latency CWL 9, so write-on latency is 7 or 6 clocks
// Notes: sync-mode pin timing is checked against a window, not one edge
`timescale 1ns/1ps
module test_dtc_term_ctrl;
    import dtc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic reset_i;
    logic psel_i;
    logic penable_i;
    logic pwrite_i;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, odt_pin_i, cke_pin_i, write_cmd_i, burst_bc4_i;
    logic [1:0] rtt_sel_o;
    logic rtt_changing_o;
    int error_cnt = 0;
    int n_checks = 0;
    always #12.5 clk_sys_i = ~clk_sys_i;
    dtc_term_ctrl DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .odt_pin_i(odt_pin_i), .cke_pin_i(cke_pin_i),
        .write_cmd_i(write_cmd_i), .burst_bc4_i(burst_bc4_i),
        .rtt_sel_o(rtt_sel_o), .rtt_changing_o(rtt_changing_o));
    dtc_ctl_model ctl (.clk_sys_i(clk_sys_i), .odt_o(odt_pin_i), .cke_o(cke_pin_i),
        .wr_o(write_cmd_i), .bc4_o(burst_bc4_i));
    task automatic stop_test;
        $display("checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
        end while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp, input logic ee);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
        chk(e, ee);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    // Edges until the select does or does not equal v, capped at 60
    task automatic wt(input logic [1:0] v, input logic eq, output int t);
        t = 0;
        while ((rtt_sel_o === v) !== eq && t < 60) begin
            @(posedge clk_sys_i);
            #1;
            t++;
        end
    endtask
    task automatic wcase(input logic [31:0] c, input logic [31:0] l, input logic b,
                         input int on, input int ex);
        int t;
        wr(DTC_LAT_OFF, l);
        wr(DTC_CTRL_OFF, c);
        ctl.send_write(b);
        wt(DTC_RTT_WR, 1'b1, t);
        chk(t, on + 1);
        chk(rtt_changing_o, 32'h1);
        wt(DTC_RTT_WR, 1'b0, t);
        chk(t, ex);
        chk(rtt_sel_o, DTC_RTT_PARK);
        repeat (4) @(posedge clk_sys_i);
    endtask
    task automatic no_write(input logic [31:0] c);
        int t;
        wr(DTC_CTRL_OFF, c);
        ctl.send_write(1'b0);
        wt(DTC_RTT_WR, 1'b1, t);
        chk(t, 60);
    endtask
    task automatic pin_case(input logic [31:0] c, input int lo, input int hi);
        int t;
        wr(DTC_CTRL_OFF, c);
        ctl.set_odt(1'b1);
        wt(DTC_RTT_NOM, 1'b1, t);
        chk(t >= lo && t <= hi, 1'b1);
        ctl.set_odt(1'b0);
        wt(DTC_RTT_PARK, 1'b1, t);
        chk(t >= lo && t <= hi, 1'b1);
    endtask
    task automatic overlap;
        int t;
        wr(DTC_CTRL_OFF, 32'h3);
        ctl.set_odt(1'b1);
        wt(DTC_RTT_NOM, 1'b1, t);
        ctl.send_write(1'b0);
        wt(DTC_RTT_WR, 1'b1, t);
        chk(t, 8);
        wt(DTC_RTT_WR, 1'b0, t);
        chk(t, 6);
        chk(rtt_sel_o, DTC_RTT_NOM);
        ctl.set_odt(1'b0);
        wt(DTC_RTT_PARK, 1'b1, t);
        chk(t >= 7 && t <= 12, 1'b1);
    endtask
    task automatic power_down;
        int t;
        wr(DTC_CTRL_OFF, 32'h21);
        ctl.set_odt(1'b1);
        wt(DTC_RTT_NOM, 1'b1, t);
        ctl.power(1'b0);
        wt(DTC_RTT_NOM, 1'b0, t);
        chk(t <= 16, 1'b1);
        repeat (10) @(posedge clk_sys_i);
        chk(rtt_sel_o, DTC_RTT_PARK);
        reg_chk(DTC_STAT_OFF, 32'h2C, 1'b0);
        ctl.power(1'b1);
        repeat (20) @(posedge clk_sys_i);
        chk(rtt_sel_o, DTC_RTT_PARK);
    endtask
    initial begin
        #(25 * 20000);
        error_cnt++;
        stop_test;
    end
    initial begin
        reset_i <= 1'b1;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        pwrite_i <= 1'b0;
        paddr_i <= 8'h00;
        pwdata_i <= 32'h0;
        repeat (5) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        reg_chk(DTC_STAT_OFF, 32'h0, 1'b0);
        reg_chk(DTC_CTRL_OFF, DTC_CTRL_RST, 1'b0);
        reg_chk(DTC_LAT_OFF, DTC_LAT_RST, 1'b0);
        wr(8'h0C, 32'h3F);
        reg_chk(8'h0C, 32'h0, 1'b1);
        reg_chk(DTC_CTRL_OFF, DTC_CTRL_RST, 1'b0);
        wcase(32'h03, 32'h09, 1'b1, 7, 4);
        wcase(32'h05, 32'h09, 1'b0, 7, 6);
        wcase(32'h13, 32'h09, 1'b1, 7, 7);
        wcase(32'h13, 32'h09, 1'b0, 7, 7);
        wcase(32'h0B, 32'h09, 1'b1, 6, 5);
        wcase(32'h0B, 32'h09, 1'b0, 6, 7);
        wcase(32'h1B, 32'h09, 1'b1, 6, 8);
        wcase(32'h1B, 32'h09, 1'b0, 6, 8);
        wcase(32'h03, 32'h0001_0209, 1'b0, 10, 6);
        wr(DTC_LAT_OFF, DTC_LAT_RST);
        no_write(32'h01);
        no_write(32'h06);
        pin_case(32'h01, 7, 12);
        pin_case(32'h00, 1, 4);
        overlap;
        power_down;
        stop_test;
    end
endmodule // test_dtc_term_ctrl
